//--- suc_baud.sv
// Bit-rate generator: 16x sampling tick and bit-rate tick
`timescale 1ns/1ps
module suc_baud (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	// Divisor in, ticks out
	input  wire logic [15:0] divisor,
	output logic             tick16_ff,
	output logic             baud_ff
);
	logic [15:0] cnt_ff;
	logic [3:0]  sub_ff;
	logic        wrap;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// Zero divisor is not guarded; it counts the full range
	assign wrap = (cnt_ff >= divisor - 16'h0001);

	// ==========================================================
	// Divide by the divisor
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_ff    <= '0;
			tick16_ff <= 1'h0;
		end else begin
			cnt_ff    <= wrap ? '0 : cnt_ff + 16'h0001;
			tick16_ff <= wrap;
		end
	end

	// ==========================================================
	// Divide the 16x tick by sixteen
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sub_ff  <= '0;
			baud_ff <= 1'h0;
		end else begin
			baud_ff <= tick16_ff && (sub_ff == suc_pkg::END_TICK);
			if (tick16_ff)
				sub_ff <= sub_ff + 4'h1;
		end
	end

	div_one_a: assert property ($past(reset_n) && $past(divisor) == 16'h0001
		&& divisor == 16'h0001 |-> tick16_ff) else $error("16x tick missing with divisor one");
	baud_tick_a: assert property (baud_ff |-> $past(tick16_ff) && $past(sub_ff) == suc_pkg::END_TICK)
		else $error("bit tick not on sixteenth 16x tick");
endmodule : suc_baud

//--- suc_peer.sv
// Serial device model that sends framed characters toward the core
`timescale 1ns/1ps
module suc_peer (
	// Clock
	input  wire logic        ref_clk,
	// Request from the bench
	input  wire logic        go,
	input  wire logic [11:0] frame,
	input  wire logic [15:0] bit_len,
	// Serial line toward the core
	output logic             line,
	output logic             busy
);
	initial begin
		line = 1'b1;
		busy = 1'b0;
	end
	// Start bit in bit 0, sent first; line idles high afterwards
	always @(posedge ref_clk) begin
		if (go && !busy) begin
			busy <= 1'b1;
			for (int i = 0; i < 12; i++) begin
				line <= frame[i];
				repeat (bit_len) @(posedge ref_clk);
			end
			line <= 1'b1;
			busy <= 1'b0;
		end
	end
endmodule : suc_peer

//--- suc_pkg.sv
// Constants, state types and helpers shared by the UART core
package suc_pkg;
	// ==========================================================
	// Register indexes; byte address is four times the index
	localparam logic [2:0] A_DATA = 3'h0;
	localparam logic [2:0] A_IER  = 3'h1;
	localparam logic [2:0] A_IIR  = 3'h2;
	localparam logic [2:0] A_LCR  = 3'h3;
	localparam logic [2:0] A_MCR  = 3'h4;
	localparam logic [2:0] A_LSR  = 3'h5;
	localparam logic [2:0] A_MSR  = 3'h6;
	localparam logic [2:0] A_SCR  = 3'h7;
	localparam int         IDX_LO = 2;
	localparam int         IDX_HI = 4;
	localparam int         ADDR_W = 8;
	// ==========================================================
	// Field positions
	localparam int L_STB = 2, L_PEN = 3, L_EPS = 4, L_STK = 5, L_BRK = 6, L_DLAB = 7;
	localparam int M_DTR = 0, M_RTS = 1, M_OUT1 = 2, M_OUT2 = 3, M_LOOP = 4;
	localparam int E_RD = 0, E_TE = 1, E_LS = 2, E_MS = 3;
	localparam int R_RI = 2;
	// ==========================================================
	// Reset values, tick counts, interrupt codes
	localparam logic [15:0] DIV_RST  = 16'h0001;
	localparam logic [3:0]  MID_TICK = 4'h7;
	localparam logic [3:0]  END_TICK = 4'hF;
	localparam logic [3:0]  IID_LS   = 4'h6;
	localparam logic [3:0]  IID_RD   = 4'h4;
	localparam logic [3:0]  IID_TE   = 4'h2;
	localparam logic [3:0]  IID_MS   = 4'h0;
	localparam logic [3:0]  IID_NONE = 4'h1;
	// ==========================================================
	// State machines
	typedef enum logic [5:0] {TS_IDLE = 6'h01, TS_START = 6'h02, TS_DATA = 6'h04,
		TS_PAR = 6'h08, TS_STOP = 6'h10, TS_HALF = 6'h20} suc_tx_st_t;
	typedef enum logic [4:0] {RS_IDLE = 5'h01, RS_START = 5'h02, RS_DATA = 5'h04,
		RS_PAR = 5'h08, RS_STOP = 5'h10} suc_rx_st_t;
	// Data bit mask for 5 to 8 bit characters
	function automatic logic [7:0] suc_mask(input logic [1:0] wls);
		return 8'hFF >> (2'h3 - wls);
	endfunction : suc_mask
endpackage : suc_pkg

//--- suc_rx.sv
// Serial receiver with false-start check and error flags
`timescale 1ns/1ps
module suc_rx (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	// Line, tick and format
	input  wire logic       tick16,
	input  wire logic       rxd,
	input  wire logic [7:0] lcr,
	// Received character
	output logic            done_ff,
	output logic [7:0]      data_ff,
	output logic            perr_ff,
	output logic            ferr_ff,
	output logic            brk_ff
);
	suc_pkg::suc_rx_st_t st_ff;
	logic [3:0]          ph_ff;
	logic [2:0]          bit_ff;
	logic [7:0]          sh_ff;
	logic                par_ff;
	logic                zero_ff;
	logic                prev_ff;
	logic                samp;
	logic                exp_par;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	assign samp    = tick16 && (ph_ff == suc_pkg::END_TICK);
	assign exp_par = lcr[suc_pkg::L_STK] ? ~lcr[suc_pkg::L_EPS] : par_ff ^ ~lcr[suc_pkg::L_EPS];

	// ==========================================================
	// Deframer
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_ff   <= suc_pkg::RS_IDLE;
			ph_ff   <= '0;
			bit_ff  <= '0;
			sh_ff   <= '0;
			par_ff  <= 1'h0;
			zero_ff <= 1'h0;
			prev_ff <= 1'h1;
			done_ff <= 1'h0;
			data_ff <= '0;
			perr_ff <= 1'h0;
			ferr_ff <= 1'h0;
			brk_ff  <= 1'h0;
		end else begin
			prev_ff <= rxd;
			done_ff <= 1'h0;
			if (tick16)
				ph_ff <= ph_ff + 4'h1;
			unique case (st_ff)
				// Falling edge only, so a held break starts nothing
				suc_pkg::RS_IDLE: if (prev_ff && !rxd) begin
					st_ff <= suc_pkg::RS_START;
					ph_ff <= '0;
				end
				suc_pkg::RS_START: if (tick16 && ph_ff == suc_pkg::MID_TICK) begin
					st_ff   <= rxd ? suc_pkg::RS_IDLE : suc_pkg::RS_DATA;
					ph_ff   <= '0;
					bit_ff  <= '0;
					par_ff  <= 1'h0;
					zero_ff <= 1'h1;
					perr_ff <= 1'h0;
				end
				suc_pkg::RS_DATA: if (samp) begin
					sh_ff   <= {rxd, sh_ff[7:1]};
					par_ff  <= par_ff ^ rxd;
					zero_ff <= zero_ff & ~rxd;
					bit_ff  <= bit_ff + 3'h1;
					if (bit_ff == 3'h4 + {1'h0, lcr[1:0]})
						st_ff <= lcr[suc_pkg::L_PEN] ? suc_pkg::RS_PAR : suc_pkg::RS_STOP;
				end
				suc_pkg::RS_PAR: if (samp) begin
					perr_ff <= rxd != exp_par;
					zero_ff <= zero_ff & ~rxd;
					st_ff   <= suc_pkg::RS_STOP;
				end
				suc_pkg::RS_STOP: if (samp) begin
					ferr_ff <= ~rxd;
					brk_ff  <= zero_ff & ~rxd;
					data_ff <= sh_ff >> (2'h3 - lcr[1:0]);
					done_ff <= 1'h1;
					st_ff   <= suc_pkg::RS_IDLE;
				end
			endcase
		end
	end

	false_start_a: assert property (st_ff == suc_pkg::RS_START && tick16 && ph_ff == suc_pkg::MID_TICK && rxd
		|=> st_ff == suc_pkg::RS_IDLE) else $error("false start not discarded");
	break_flag_a: assert property (done_ff && brk_ff |-> ferr_ff && data_ff == '0)
		else $error("break without framing error or with data");
	false_start_c: cover property (st_ff == suc_pkg::RS_START ##1 st_ff == suc_pkg::RS_IDLE);
endmodule : suc_rx

//--- suc_uart.sv
// Synchronous UART core top: APB registers, transmitter, interrupts, modem lines
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
module suc_uart (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             driver_disable,
	// Interrupt and bit tick
	output logic             irq,
	output logic             baud_tick,
	// Serial line
	input  wire logic        serial_in,
	output logic             serial_out,
	// Modem control, active low
	input  wire logic        send_permit_in_n,
	input  wire logic        modem_ready_in_n,
	input  wire logic        call_alert_in_n,
	input  wire logic        carrier_detect_in_n,
	output logic             send_request_out_n,
	output logic             terminal_ready_out_n,
	output logic             aux1_out_n,
	output logic             aux2_out_n
);
	// ==========================================================
	// Declarations
	logic [15:0]         div_ff;
	logic [3:0]          ier_ff;
	logic [7:0]          lcr_ff;
	logic [4:0]          mcr_ff;
	logic [7:0]          scr_ff;
	logic [7:0]          thr_ff;
	logic                thr_full_ff;
	logic [7:0]          rbr_ff;
	logic                dr_ff;
	logic                oe_ff;
	logic [2:0]          err_ff;
	logic                fresh_ff;
	logic [3:0]          prev_ff;
	logic [3:0]          delta_ff;
	logic                thre_int_ff;
	suc_pkg::suc_tx_st_t tst_ff;
	logic [7:0]          tsr_ff;
	logic [2:0]          tbit_ff;
	logic                tpar_ff;
	logic                two_ff;
	logic [3:0]          half_ff;
	logic                txo_ff;
	logic [2:0]          idx;
	logic                bad;
	logic                dlab;
	logic                acc;
	logic                wr_acc;
	logic                rd_acc;
	logic                rd_setup;
	logic                rd_clr;
	logic                thr_wr;
	logic [7:0]          wd;
	logic [7:0]          rd_val;
	logic [3:0]          iid;
	logic [3:0]          ms_cur;
	logic [3:0]          ms_ev;
	logic                tick16;
	logic                btick;
	logic                tx_take;
	logic                stop_last;
	logic                par_bit;
	logic                tx_line;
	logic                loop;
	logic                rx_in;
	logic                rx_done;
	logic [7:0]          rx_data;
	logic [2:0]          rx_err;
	logic                ls_pend;
	logic                rd_pend;
	logic                te_pend;
	logic                ms_pend;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// ==========================================================
	// Address decode, straight from the bus each access
	assign idx      = paddr[suc_pkg::IDX_HI:suc_pkg::IDX_LO];
	assign bad      = |paddr[suc_pkg::ADDR_W-1:suc_pkg::IDX_HI+1];
	assign dlab     = lcr_ff[suc_pkg::L_DLAB];
	assign acc      = psel & penable & pready;
	assign wr_acc   = acc & pwrite & ~bad;
	assign rd_acc   = acc & ~pwrite & ~bad;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign rd_clr   = rd_acc & ~fresh_ff;
	assign thr_wr   = wr_acc & (idx == suc_pkg::A_DATA) & ~dlab;
	assign wd       = pwdata[7:0];
	assign loop     = mcr_ff[suc_pkg::M_LOOP];

	// ==========================================================
	// Bus answer: zero wait, read data caught in the setup cycle
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata         <= '0;
			pready         <= 1'h0;
			pslverr        <= 1'h0;
			driver_disable <= 1'h1;
		end else begin
			pready         <= psel & ~penable;
			pslverr        <= psel & ~penable & bad;
			driver_disable <= ~rd_setup;
			if (rd_setup)
				prdata <= {24'h00_0000, bad ? 8'h00 : rd_val};
		end
	end

	// ==========================================================
	// Configuration registers
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_ff <= suc_pkg::DIV_RST;
			ier_ff <= '0;
			lcr_ff <= '0;
			mcr_ff <= '0;
			scr_ff <= '0;
		end else if (wr_acc) begin
			case (idx)
				suc_pkg::A_DATA: if (dlab) begin
					div_ff[7:0] <= wd;
				end
				suc_pkg::A_IER: if (dlab) begin
					div_ff[15:8] <= wd;
				end else begin
					ier_ff <= wd[3:0];
				end
				suc_pkg::A_LCR: lcr_ff <= wd;
				suc_pkg::A_MCR: mcr_ff <= wd[4:0];
				suc_pkg::A_SCR: scr_ff <= wd;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Transmit holding register
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			thr_ff      <= '0;
			thr_full_ff <= 1'h0;
		end else if (thr_wr) begin
			thr_ff      <= wd;
			thr_full_ff <= 1'h1;
		end else if (tx_take) begin
			thr_full_ff <= 1'h0;
		end
	end

	// ==========================================================
	// Receive holding register and line status
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rbr_ff   <= '0;
			dr_ff    <= 1'h0;
			oe_ff    <= 1'h0;
			fresh_ff <= 1'h0;
		end else begin
			// Character landing after the read was caught stays unread
			if (rx_done)
				fresh_ff <= 1'h1;
			else if (rd_setup)
				fresh_ff <= 1'h0;
			if (rx_done)
				rbr_ff <= rx_data;
			if (rx_done)
				dr_ff <= 1'h1;
			else if (rd_clr && idx == suc_pkg::A_DATA && !dlab)
				dr_ff <= 1'h0;
			if (rx_done && dr_ff && !(rd_clr && idx == suc_pkg::A_DATA && !dlab))
				oe_ff <= 1'h1;
			else if (rd_clr && idx == suc_pkg::A_LSR)
				oe_ff <= 1'h0;
		end
	end

	// Parity, framing and break flags; new error wins over the clear
	for (genvar g = 0; g < 3; g++) begin : g_err
		always_ff @(posedge ref_clk or negedge reset_n) begin
			if (!reset_n)
				err_ff[g] <= 1'h0;
			else if (rx_done && rx_err[g])
				err_ff[g] <= 1'h1;
			else if (rd_clr && idx == suc_pkg::A_LSR)
				err_ff[g] <= 1'h0;
		end
	end

	// ==========================================================
	// Modem status; loopback ties outputs back to inputs
	assign ms_cur = loop ? {mcr_ff[suc_pkg::M_OUT2], mcr_ff[suc_pkg::M_OUT1], mcr_ff[suc_pkg::M_DTR],
		mcr_ff[suc_pkg::M_RTS]} : ~{carrier_detect_in_n, call_alert_in_n, modem_ready_in_n,
		send_permit_in_n};
	assign ms_ev  = (prev_ff ^ ms_cur) & ~(4'h1 << suc_pkg::R_RI)
		| (prev_ff & ~ms_cur & (4'h1 << suc_pkg::R_RI));

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_ff  <= '0;
			delta_ff <= '0;
		end else begin
			prev_ff <= ms_cur;
			if (rd_acc && idx == suc_pkg::A_MSR)
				delta_ff <= ms_ev;
			else
				delta_ff <= delta_ff | ms_ev;
		end
	end

	// ==========================================================
	// Transmitter; bits move on the bit tick
	assign stop_last = ~lcr_ff[suc_pkg::L_STB] | two_ff;
	assign tx_take   = thr_full_ff & btick & ((tst_ff == suc_pkg::TS_IDLE)
		| ((tst_ff == suc_pkg::TS_STOP) & stop_last));
	assign par_bit   = lcr_ff[suc_pkg::L_STK] ? ~lcr_ff[suc_pkg::L_EPS] : tpar_ff ^ ~lcr_ff[suc_pkg::L_EPS];
	assign tx_line   = txo_ff & ~lcr_ff[suc_pkg::L_BRK];

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tst_ff  <= suc_pkg::TS_IDLE;
			tsr_ff  <= '0;
			tbit_ff <= '0;
			tpar_ff <= 1'h0;
			two_ff  <= 1'h0;
			half_ff <= '0;
			txo_ff  <= 1'h1;
		end else begin
			if (tick16)
				half_ff <= half_ff + 4'h1;
			unique case (tst_ff)
				suc_pkg::TS_IDLE: if (tx_take) begin
					tsr_ff <= thr_ff & suc_pkg::suc_mask(lcr_ff[1:0]);
					txo_ff <= 1'h0;
					tst_ff <= suc_pkg::TS_START;
				end
				suc_pkg::TS_START: if (btick) begin
					txo_ff  <= tsr_ff[0];
					tsr_ff  <= tsr_ff >> 1;
					tpar_ff <= tsr_ff[0];
					tbit_ff <= '0;
					tst_ff  <= suc_pkg::TS_DATA;
				end
				suc_pkg::TS_DATA: if (btick) begin
					if (tbit_ff == 3'h4 + {1'h0, lcr_ff[1:0]}) begin
						txo_ff <= lcr_ff[suc_pkg::L_PEN] ? par_bit : 1'h1;
						tst_ff <= lcr_ff[suc_pkg::L_PEN] ? suc_pkg::TS_PAR : suc_pkg::TS_STOP;
						two_ff <= 1'h0;
					end else begin
						txo_ff  <= tsr_ff[0];
						tsr_ff  <= tsr_ff >> 1;
						tpar_ff <= tpar_ff ^ tsr_ff[0];
						tbit_ff <= tbit_ff + 3'h1;
					end
				end
				suc_pkg::TS_PAR: if (btick) begin
					txo_ff <= 1'h1;
					two_ff <= 1'h0;
					tst_ff <= suc_pkg::TS_STOP;
				end
				suc_pkg::TS_STOP: if (btick) begin
					if (tx_take) begin
						tsr_ff <= thr_ff & suc_pkg::suc_mask(lcr_ff[1:0]);
						txo_ff <= 1'h0;
						tst_ff <= suc_pkg::TS_START;
					end else if (stop_last) begin
						tst_ff <= suc_pkg::TS_IDLE;
					end else if (lcr_ff[1:0] == 2'h0) begin
						half_ff <= '0;
						tst_ff  <= suc_pkg::TS_HALF;
					end else begin
						two_ff <= 1'h1;
					end
				end
				// Half stop; next start waits for the following bit tick
				suc_pkg::TS_HALF: if (tick16 && half_ff == suc_pkg::MID_TICK) begin
					tst_ff <= suc_pkg::TS_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Interrupt priority and transmitter-empty source
	assign ls_pend = ier_ff[suc_pkg::E_LS] & (oe_ff | (|err_ff));
	assign rd_pend = ier_ff[suc_pkg::E_RD] & dr_ff;
	assign te_pend = ier_ff[suc_pkg::E_TE] & thre_int_ff;
	assign ms_pend = ier_ff[suc_pkg::E_MS] & (|delta_ff);
	assign iid     = ls_pend ? suc_pkg::IID_LS : rd_pend ? suc_pkg::IID_RD : te_pend ? suc_pkg::IID_TE
		: ms_pend ? suc_pkg::IID_MS : suc_pkg::IID_NONE;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			thre_int_ff <= 1'h0;
			irq         <= 1'h0;
		end else begin
			irq <= ~iid[0];
			if (tx_take || (wr_acc && idx == suc_pkg::A_IER && !dlab && wd[suc_pkg::E_TE] && !thr_full_ff))
				thre_int_ff <= 1'h1;
			else if (thr_wr || (rd_acc && idx == suc_pkg::A_IIR && iid == suc_pkg::IID_TE))
				thre_int_ff <= 1'h0;
		end
	end

	// ==========================================================
	// Read multiplexer
	always_comb begin
		rd_val = '0;
		case (idx)
			suc_pkg::A_DATA: rd_val = dlab ? div_ff[7:0] : rbr_ff;
			suc_pkg::A_IER:  rd_val = dlab ? div_ff[15:8] : {4'h0, ier_ff};
			suc_pkg::A_IIR:  rd_val = {4'h0, iid};
			suc_pkg::A_LCR:  rd_val = lcr_ff;
			suc_pkg::A_MCR:  rd_val = {3'h0, mcr_ff};
			suc_pkg::A_LSR:  rd_val = {1'h0, ~thr_full_ff & (tst_ff == suc_pkg::TS_IDLE), ~thr_full_ff,
				err_ff, oe_ff, dr_ff};
			suc_pkg::A_MSR:  rd_val = {ms_cur, delta_ff};
			suc_pkg::A_SCR:  rd_val = scr_ff;
			default:         rd_val = '0;
		endcase
	end

	// ==========================================================
	// Serial and modem pins; loopback parks them inactive
	assign rx_in = loop ? tx_line : serial_in;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			serial_out           <= 1'h1;
			send_request_out_n   <= 1'h1;
			terminal_ready_out_n <= 1'h1;
			aux1_out_n           <= 1'h1;
			aux2_out_n           <= 1'h1;
		end else begin
			serial_out           <= loop | tx_line;
			send_request_out_n   <= loop | ~mcr_ff[suc_pkg::M_RTS];
			terminal_ready_out_n <= loop | ~mcr_ff[suc_pkg::M_DTR];
			aux1_out_n           <= loop | ~mcr_ff[suc_pkg::M_OUT1];
			aux2_out_n           <= loop | ~mcr_ff[suc_pkg::M_OUT2];
		end
	end

	// ==========================================================
	// Submodules
	suc_baud u_baud (
		.ref_clk   (ref_clk),
		.reset_n   (reset_n),
		.divisor   (div_ff),
		.tick16_ff (tick16),
		.baud_ff   (btick)
	);

	assign baud_tick = btick;

	suc_rx u_rx (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.tick16  (tick16),
		.rxd     (rx_in),
		.lcr     (lcr_ff),
		.done_ff (rx_done),
		.data_ff (rx_data),
		.perr_ff (rx_err[0]),
		.ferr_ff (rx_err[1]),
		.brk_ff  (rx_err[2])
	);

	// ==========================================================
	// Checks
	div_reset_a: assert property (!$past(reset_n) |-> div_ff == suc_pkg::DIV_RST)
		else $error("divisor not one after reset");
	read_hold_a: assert property (!rd_setup |=> $stable(prdata))
		else $error("read data changed without a read");
	drv_dis_a: assert property (psel && penable && !pwrite |-> !driver_disable)
		else $error("driver disable high during read access");
	thr_load_a: assert property (thr_wr |=> thr_full_ff && thr_ff == $past(wd))
		else $error("transmit byte not held");
	rx_store_a: assert property (rx_done |=> dr_ff && rbr_ff == $past(rx_data))
		else $error("received byte not stored");
	overrun_a: assert property (rx_done && dr_ff && !rd_acc |=> oe_ff)
		else $error("overrun not flagged");
	irq_prio_a: assert property (ls_pend |-> iid == suc_pkg::IID_LS ##1 irq)
		else $error("line status not top priority");
	loop_pin_a: assert property (loop |=> serial_out && send_request_out_n)
		else $error("pins active during loopback");
	start_bit_a: assert property (tx_take && !loop && !lcr_ff[suc_pkg::L_BRK] ##1 !lcr_ff[suc_pkg::L_BRK]
		|=> !serial_out) else $error("start bit missing");
	rx_char_c: cover property (rx_done && !(|rx_err));
	half_stop_c: cover property (tst_ff == suc_pkg::TS_HALF ##1 tst_ff == suc_pkg::TS_IDLE);
	irq_rise_c: cover property ($rose(irq));
endmodule : suc_uart

//--- test_sync_uart_core.sv
// Directed bench for the UART core over APB and the serial line
`timescale 1ns/1ps
module test_sync_uart_core;
	logic        ref_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic        pready, pslverr, irq, baud_tick, serial_out, line, busy, rts_n, dtr_n, e, dd;
	logic        cts_n = 1'b1;
	logic [11:0] frame = 12'hFFF;
	logic [15:0] BIT = 16'h0020;
	int          error_cnt = 0, n_compared = 0, t;
	always #25 ref_clk = ~ref_clk;
	suc_uart u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.driver_disable(dd), .irq(irq), .baud_tick(baud_tick), .serial_in(line), .serial_out(serial_out),
		.send_permit_in_n(cts_n), .modem_ready_in_n(1'b1), .call_alert_in_n(1'b1), .carrier_detect_in_n(1'b1),
		.send_request_out_n(rts_n), .terminal_ready_out_n(dtr_n), .aux1_out_n(), .aux2_out_n());
	suc_peer u_peer (.ref_clk(ref_clk), .go(go), .frame(frame), .bit_len(BIT), .line(line), .busy(busy));
	// ====
	// Bus and line tasks
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			error_cnt++;
			$display("mismatch %0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		if (!w) chk(dd, 1'b0);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		apb(1'b0, a, 8'h00);
		chk(q, {24'h00_0000, x});
	endtask : rd
	task automatic send(input logic [7:0] d, input logic bad, input logic brk);
		frame <= brk ? 12'h000 : {2'b11, bad ^ (^d), d, 1'b0};
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		do @(posedge ref_clk); while (busy === 1'b1);
	endtask : send
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	// ====
	// Tests
	initial begin
		#1ms;
		error_cnt++;
		stop_test();
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		rd(8'h08, 8'h01);
		rd(8'h14, 8'h60);
		apb(1'b1, 8'h0C, 8'h83);
		rd(8'h00, 8'h01);
		apb(1'b1, 8'h00, 8'h02);
		rd(8'h00, 8'h02);
		apb(1'b1, 8'h0C, 8'h1B);
		do @(posedge ref_clk); while (baud_tick !== 1'b1);
		t = 0;
		do begin
			@(posedge ref_clk);
			t++;
		end while (baud_tick !== 1'b1);
		chk(t, BIT);
		$display("test divisor done");
		apb(1'b1, 8'h04, 8'h02);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1'b1);
		rd(8'h08, 8'h02);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1'b0);
		apb(1'b1, 8'h00, 8'hA5);
		t = 0;
		while (serial_out !== 1'b0 && t < 300) begin
			@(posedge ref_clk);
			t++;
		end
		repeat (BIT / 2) @(posedge ref_clk);
		for (int i = 0; i < 11; i++) begin
			chk(serial_out, ({1'b1, ^8'hA5, 8'hA5, 1'b0} >> i) & 32'h0000_0001);
			repeat (BIT) @(posedge ref_clk);
		end
		$display("test transmit done");
		apb(1'b1, 8'h04, 8'h05);
		send(8'h3C, 1'b0, 1'b0);
		rd(8'h08, 8'h04);
		rd(8'h14, 8'h61);
		rd(8'h00, 8'h3C);
		send(8'h5A, 1'b1, 1'b0);
		rd(8'h08, 8'h06);
		rd(8'h14, 8'h65);
		rd(8'h00, 8'h5A);
		send(8'h11, 1'b0, 1'b0);
		send(8'h22, 1'b0, 1'b0);
		rd(8'h14, 8'h63);
		rd(8'h00, 8'h22);
		send(8'h00, 1'b0, 1'b1);
		rd(8'h14, 8'h79);
		rd(8'h00, 8'h00);
		$display("test receive done");
		apb(1'b1, 8'h1C, 8'h5A);
		rd(8'h1C, 8'h5A);
		apb(1'b1, 8'h20, 8'hFF);
		chk(e, 1'b1);
		chk(prdata, 32'h0000_005A);
		rd(8'h20, 8'h00);
		chk(e, 1'b1);
		apb(1'b1, 8'h10, 8'h03);
		repeat (2) @(posedge ref_clk);
		chk({rts_n, dtr_n}, 2'b00);
		cts_n <= 1'b0;
		rd(8'h18, 8'h11);
		$display("test access done");
		apb(1'b1, 8'h0C, 8'h02);
		apb(1'b1, 8'h10, 8'h10);
		apb(1'b1, 8'h00, 8'hC1);
		t = 0;
		do begin
			apb(1'b0, 8'h14, 8'h00);
			t++;
		end while (q[0] !== 1'b1 && t < 200);
		chk(serial_out, 1'b1);
		rd(8'h00, 8'h41);
		$display("test loopback done");
		stop_test();
	end
endmodule : test_sync_uart_core
